// File: dual_port_semaphore_flags_tb.sv
// self-checking bench: host controller on one port, bench on the other
`timescale 1ns/1ps
module dual_port_semaphore_flags_tb;
  import sem_host_pkg::*;
  logic         core_clk_i = 1'b0;
  logic         rst_n_i = 1'b0;
  logic         clk_en_i = 1'b1;
  logic         cmd_valid_i = 1'b0;
  sem_cmd_type  cmd_i = '0;
  logic         cmd_ready_o;
  logic         done_o;
  logic         granted_o;
  logic         read_error_o;
  logic [7:0]   held_mask_o;
  logic [7:0]   pending_mask_o;
  sem_pins_type pins_o;
  logic [35:0]  data_o;
  logic         data_oe_o;
  logic [35:0]  data_i;
  logic [35:0]  dev_data;
  logic         b_sel_n = 1'b1;
  logic         b_wnr = 1'b1;
  logic         b_oe_n = 1'b1;
  logic         b_d0 = 1'b1;
  logic [5:0]   b_addr = 6'h00;
  logic         b_q;
  logic [7:0]   exp_held = 8'h00;
  logic [7:0]   exp_pend = 8'h00;
  logic [17:0]  exp_q[$];
  logic [2:0]   f;
  int           fail_count = 0;
  int           samples_checked = 0;
  int           seed_v;
  always #2.5 core_clk_i = ~core_clk_i;
  assign data_i = data_oe_o ? data_o : dev_data;
  sem_host_ctrl i_sem_host_ctrl (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .granted_o(granted_o),
    .read_error_o(read_error_o), .held_mask_o(held_mask_o), .pending_mask_o(pending_mask_o),
    .pins_o(pins_o), .data_o(data_o), .data_oe_o(data_oe_o), .data_i(data_i)
  );
  sem_flag_model i_sem_flag_model (
    .a_pins_i(pins_o), .a_data_i(data_i), .a_data_o(dev_data), .b_sel_n_i(b_sel_n), .b_wnr_i(b_wnr),
    .b_oe_n_i(b_oe_n), .b_addr_i(b_addr), .b_d0_i(b_d0), .b_q_o(b_q)
  );
  // ****************************************
  // tasks
  // ****************************************
  task automatic cmp(input logic [17:0] e, input logic [17:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %0t exp %h got %h", $time, e, g);
    end
  endtask
  // n extra cycles of valid while busy, with another op, must be ignored
  task automatic run(input sem_op_type op, input logic [2:0] fl, input logic g, input int n);
    int i;
    cmd_i = '{op, fl};
    cmd_valid_i = 1'b1;
    for (i = 0; i < 80 && cmd_ready_o !== 1'b1; i++) @(posedge core_clk_i) #1;
    @(posedge core_clk_i) #1;
    cmd_i.op = OP_INIT;
    repeat (n) @(posedge core_clk_i) #1;
    cmd_valid_i = 1'b0;
    if (op == OP_INIT) {exp_held, exp_pend} = 16'h0000;
    else if (op == OP_RELEASE) {exp_held[fl], exp_pend[fl]} = 2'b00;
    else {exp_held[fl], exp_pend[fl]} = {g, op == OP_CLAIM ? !g : exp_pend[fl] && !g};
    exp_q.push_back({g, 1'b0, exp_held, exp_pend});
    for (i = 0; i < 80 && done_o !== 1'b1; i++) @(posedge core_clk_i) #1;
    if (done_o !== 1'b1)
    begin
      fail_count++;
      $display("MISMATCH %0t command never completed", $time);
      end_sim();
    end
  endtask
  task automatic b_wr(input logic [2:0] fl, input logic v);
    b_addr = {3'($urandom), fl};
    b_d0 = v;
    b_sel_n = 1'b0;
    @(posedge core_clk_i) #1 b_wnr = 1'b0;
    @(posedge core_clk_i) #1 b_wnr = 1'b1;
    @(posedge core_clk_i) #1 b_sel_n = 1'b1;
    // select idles a full cycle before the next access
    @(posedge core_clk_i) #1;
  endtask
  // select and output enable drop after each read, else the latch holds
  task automatic b_rd(input logic [2:0] fl, input logic e);
    b_addr = {3'($urandom), fl};
    b_sel_n = 1'b0;
    @(posedge core_clk_i) #1 b_oe_n = 1'b0;
    @(posedge core_clk_i) #1 cmp(18'(e), 18'(b_q));
    b_oe_n = 1'b1;
    b_sel_n = 1'b1;
    @(posedge core_clk_i) #1;
  endtask
  task automatic end_sim();
    if (fail_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge core_clk_i)
    if (done_o === 1'b1)
    begin
      if (exp_q.size() == 0) cmp(18'h00000, 18'h3FFFF);
      else cmp(exp_q.pop_front(), {granted_o, read_error_o, held_mask_o, pending_mask_o});
    end
  initial
  begin
    #50us;
    fail_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_sim();
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    seed_v = $urandom(32'h4E96);
    repeat (3) @(posedge core_clk_i);
    #1 rst_n_i = 1'b1;
    run(OP_INIT, 3'h0, 1'b0, 0);
    for (int i = 0; i < 8; i++) b_wr(3'(i), 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      run(OP_CLAIM, 3'(i), 1'b1, 0);
      b_rd(3'(i), 1'b1);
    end
    f = 3'($urandom);
    b_wr(f + 3'h1, 1'b1);
    run(OP_TEST, f + 3'h1, 1'b1, 0);
    b_wr(f, 1'b0);
    run(OP_TEST, f, 1'b1, 0);
    b_rd(f, 1'b1);
    run(OP_RELEASE, f, 1'b0, 3);
    b_rd(f, 1'b0);
    run(OP_CLAIM, f, 1'b0, 0);
    run(OP_TEST, f, 1'b0, 0);
    b_wr(f, 1'b1);
    fork
      run(OP_TEST, f, 1'b1, 0);
      begin
        repeat (3) @(posedge core_clk_i) #1;
        clk_en_i = 1'b0;
        repeat (4) @(posedge core_clk_i) #1;
        clk_en_i = 1'b1;
      end
    join
    run(OP_RELEASE, f, 1'b0, 0);
    b_rd(f, 1'b1);
    // far side strobe ends first, so its claim must win and ours stays pending
    fork
      run(OP_CLAIM, f, 1'b0, 0);
      b_wr(f, 1'b0);
    join
    b_rd(f, 1'b0);
    b_wr(f, 1'b1);
    run(OP_RELEASE, f, 1'b0, 0);
    repeat (6)
    begin
      f = 3'($urandom);
      run(OP_RELEASE, f, 1'b0, 0);
      b_wr(f, 1'b0);
      run(OP_CLAIM, f, 1'b0, 0);
      run(OP_RELEASE, f, 1'b0, 0);
      b_wr(f, 1'b1);
      run(OP_TEST, f, 1'b0, 0);
      run(OP_CLAIM, f, 1'b1, 0);
    end
    repeat (4) @(posedge core_clk_i);
    end_sim();
  end
endmodule

// File: sem_flag_model.sv
// behavioural two-port semaphore flag device
`timescale 1ns/1ps
module sem_flag_model #(
  parameter int DATA_W = 36
) (
  input  wire sem_host_pkg::sem_pins_type a_pins_i,
  input  wire logic [DATA_W-1:0]          a_data_i,
  output logic      [DATA_W-1:0]          a_data_o,
  input  wire logic                       b_sel_n_i,
  input  wire logic                       b_wnr_i,
  input  wire logic                       b_oe_n_i,
  input  wire logic [5:0]                 b_addr_i,
  input  wire logic                       b_d0_i,
  output logic                            b_q_o
);
  import sem_host_pkg::*;
  // ****************************************
  // flag state
  // ****************************************
  // request latches and owners, apart from any array
  // power-up is not kind: far side owns all flags until it writes ones, then this side owns any it has not yet written a one to
  logic [7:0] req_a = 8'h00;
  logic [7:0] req_b = 8'h00;
  logic [7:0] own_a = 8'h00;
  logic [7:0] own_b = 8'hFF;
  logic       q_a = 1'b1;
  logic       q_b = 1'b1;
  logic       a_rd;
  logic       b_rd;
  task automatic wr(input logic sb, input logic [2:0] f, input logic v);
    if (sb) req_b[f] = v;
    else req_a[f] = v;
    if (!(own_a[f] && !req_a[f]) && !(own_b[f] && !req_b[f]))
    begin
      own_a[f] = !req_a[f] && (!sb || req_b[f]);
      own_b[f] = !req_b[f] && !own_a[f];
    end
  endtask
  // write lands at strobe end, low bits, bit 0
  always @(posedge a_pins_i.write_not_read)
    if (!a_pins_i.flag_space_select_n && a_pins_i.chip_enable_n && !a_pins_i.byte_lane0_enable_n)
      wr(1'b0, a_pins_i.addr, a_data_i[0]);
  always @(posedge b_wnr_i)
    if (!b_sel_n_i)
      wr(1'b1, b_addr_i[2:0], b_d0_i);
  // value latched as select, lane and output enable go active
  assign a_rd = !a_pins_i.flag_space_select_n && !a_pins_i.byte_lane0_enable_n
    && !a_pins_i.output_enable_n && a_pins_i.write_not_read;
  assign b_rd = !b_sel_n_i && !b_oe_n_i && b_wnr_i;
  // a side reads zero only while it owns
  always @(posedge a_rd) q_a = !own_a[a_pins_i.addr];
  always @(posedge b_rd) q_b = !own_b[b_addr_i[2:0]];
  // spread on all bits; a released bus shows the inverse
  assign a_data_o = a_rd ? {DATA_W{q_a}} : {DATA_W{!q_a}};
  assign b_q_o = b_rd ? q_b : !q_b;
endmodule

// File: sem_host_ctrl.sv
// host-side controller driving one port of the semaphore flag space
`timescale 1ns/1ps
// Operation
// - write zero claims, write one releases
// - select low, ram access style pins
// - drop select between repeated reads
// - claim writes zero, then reads back
// - failed claim: keep reading or release
// - init writes one to all flags
// - chip enable high for flag space
module sem_host_ctrl
  import sem_host_pkg::*;
#(
  parameter int DATA_W = 36
) (
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_n_i,
  input  wire logic                         clk_en_i,
  input  wire logic                         cmd_valid_i,
  input  wire sem_host_pkg::sem_cmd_type    cmd_i,
  output logic                              cmd_ready_o,
  output logic                              done_o,
  output logic                              granted_o,
  output logic                              read_error_o,
  output logic [sem_host_pkg::FLAG_COUNT-1:0] held_mask_o,
  output logic [sem_host_pkg::FLAG_COUNT-1:0] pending_mask_o,
  output sem_host_pkg::sem_pins_type        pins_o,
  output logic [DATA_W-1:0]                 data_o,
  output logic                              data_oe_o,
  input  wire logic [DATA_W-1:0]            data_i
);

  import sem_host_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_GAP
  } state_type;

  state_type             state;
  logic [CNT_W-1:0]      cnt;
  sem_op_type            op;
  logic [FLAG_IDX_W-1:0] flag;
  logic                  step_write;
  logic                  step_val;
  logic                  read_val;
  logic [DATA_W-1:0]     data_sync;
  logic                  last_step;

  sem_pin_sync #(
    .WIDTH (DATA_W)
  ) u_data_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .clk_en_i   (clk_en_i),
    .async_i    (data_i),
    .sync_o     (data_sync)
  );

  // a claim is two steps, init walks all flags, others are one step
  always_comb
  begin
    case (op)
      OP_CLAIM: last_step = !step_write;
      OP_INIT:  last_step = (flag == FLAG_LAST);
      default:  last_step = 1'b1;
    endcase
  end

  // ****************************************
  // access sequencer
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state      <= ST_IDLE;
      cnt        <= CNT_ZERO;
      op         <= OP_TEST;
      flag       <= FLAG_FIRST;
      step_write <= 1'b0;
      step_val   <= FLAG_RELEASE_VAL;
      read_val   <= FLAG_RELEASE_VAL;
    end
    else if (clk_en_i)
    begin
      // counts run down by default; a state that needs a fresh count reloads it
      cnt <= cnt - CNT_ONE;
      case (state)
        ST_IDLE:
        begin
          if (cmd_valid_i && cmd_ready_o)
          begin
            op    <= cmd_i.op;
            cnt   <= SETUP_CYC;
            state <= ST_SETUP;
            step_write <= (cmd_i.op != OP_TEST);
            step_val   <= (cmd_i.op == OP_CLAIM) ? FLAG_CLAIM_VAL : FLAG_RELEASE_VAL;
            flag       <= (cmd_i.op == OP_INIT) ? FLAG_FIRST : cmd_i.flag;
          end
        end
        ST_SETUP:
        begin
          if (cnt == CNT_ONE)
          begin
            cnt   <= step_write ? WRITE_CYC : READ_CYC;
            state <= ST_STROBE;
          end
        end
        ST_STROBE:
        begin
          if (cnt == CNT_ONE)
          begin
            if (!step_write)
            begin
              read_val <= &data_sync;
            end
            state <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          cnt   <= GAP_CYC;
          state <= ST_GAP;
        end
        ST_GAP:
        begin
          // select stays high through the gap
          if (cnt == CNT_ONE)
          begin
            if (last_step)
            begin
              state <= ST_IDLE;
            end
            else
            begin
              cnt   <= SETUP_CYC;
              state <= ST_SETUP;
              // claim reads back; init walks on, writing
              step_write <= (op == OP_INIT);
              flag       <= (op == OP_INIT) ? flag + FLAG_IDX_W'(1) : flag;
            end
          end
        end
        default:
        begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      pins_o    <= PINS_IDLE;
      data_o    <= '0;
      data_oe_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      pins_o    <= PINS_IDLE;
      data_o    <= '0;
      data_oe_o <= 1'b0;
      if (state == ST_SETUP || state == ST_STROBE || state == ST_HOLD)
      begin
        // chip enable stays high, select low
        pins_o.flag_space_select_n <= 1'b0;
        // lane 0 enable as for a ram access
        pins_o.byte_lane0_enable_n <= 1'b0;
        // only the low three bits exist
        pins_o.addr                <= flag;
      end
      // value on bit 0, rest zero, held past the strobe
      if (step_write && ((state == ST_SETUP && cnt == CNT_ONE) || state == ST_STROBE || state == ST_HOLD))
      begin
        data_o[0] <= step_val;
        data_oe_o <= 1'b1;
      end
      if (state == ST_STROBE && step_write)
      begin
        pins_o.write_not_read <= cnt == CNT_ONE;
      end
      // output enable opens the latched read
      if (!step_write && ((state == ST_SETUP && cnt == CNT_ONE) || state == ST_STROBE))
      begin
        pins_o.output_enable_n <= (state == ST_STROBE) && (cnt == CNT_ONE);
      end
    end
  end

  // ****************************************
  // ownership book-keeping
  // ****************************************
  logic read_done;
  logic read_won;

  assign read_done = (state == ST_HOLD) && !step_write;
  assign read_won  = (read_val == FLAG_CLAIM_VAL);

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      held_mask_o    <= '0;
      pending_mask_o <= '0;
      granted_o      <= 1'b0;
      read_error_o   <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (read_done)
      begin
        granted_o          <= read_won;
        held_mask_o[flag]  <= read_won;
        // mixed bits mean a bad read
        read_error_o       <= (|data_sync) && !(&data_sync);
        if (read_won)
        begin
          // pending request may have been handed over
          pending_mask_o[flag] <= 1'b0;
        end
        else if (op == OP_CLAIM)
        begin
          pending_mask_o[flag] <= 1'b1;
        end
      end
      if (state == ST_HOLD && step_write && step_val == FLAG_RELEASE_VAL)
      begin
        held_mask_o[flag]    <= 1'b0;
        pending_mask_o[flag] <= 1'b0;
        granted_o            <= 1'b0;
      end
    end
  end

  // ****************************************
  // command handshake
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cmd_ready_o <= 1'b1;
      done_o      <= 1'b0;
    end
    else if (clk_en_i)
    begin
      done_o <= 1'b0;
      if (state == ST_IDLE && cmd_valid_i && cmd_ready_o)
      begin
        cmd_ready_o <= 1'b0;
      end
      else if (state == ST_GAP && cnt == CNT_ONE && last_step)
      begin
        cmd_ready_o <= 1'b1;
        done_o      <= 1'b1;
      end
    end
  end

endmodule

// File: sem_host_ctrl_assertions.sv
// concurrent checks on the semaphore host controller ports
`timescale 1ns/1ps
module sem_host_ctrl_assertions #(
  parameter int DATA_W = 36
) (
  input wire logic                       core_clk_i,
  input wire logic                       rst_n_i,
  input wire logic                       clk_en_i,
  input wire logic                       cmd_valid_i,
  input wire sem_host_pkg::sem_cmd_type  cmd_i,
  input wire logic                       cmd_ready_o,
  input wire logic                       done_o,
  input wire sem_host_pkg::sem_pins_type pins_o,
  input wire logic [DATA_W-1:0]          data_o,
  input wire logic                       data_oe_o
);
  import sem_host_pkg::*;
  logic acc;
  assign acc = cmd_valid_i && cmd_ready_o;
  // ****************************************
  // pin protocol
  // ****************************************
  // frozen cycles stretch every count, so they cancel attempts
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i || !clk_en_i);
  chk_ce_stays_high: assert property (pins_o.chip_enable_n)
    else $error("chip enable driven low");
  chk_data_bit0: assert property (data_oe_o |-> data_o[DATA_W-1:1] == '0)
    else $error("write data beyond bit 0");
  chk_write_frame: assert property (!pins_o.write_not_read |-> data_oe_o && pins_o.output_enable_n
    && !pins_o.flag_space_select_n && !pins_o.byte_lane0_enable_n)
    else $error("write strobe outside select");
  chk_write_end: assert property ($fell(pins_o.write_not_read) |-> ##[1:3]
    $rose(pins_o.write_not_read) ##0 data_oe_o)
    else $error("write data gone before strobe end");
  chk_read_frame: assert property (!pins_o.output_enable_n |-> !pins_o.flag_space_select_n
    && !pins_o.byte_lane0_enable_n && pins_o.write_not_read && !data_oe_o)
    else $error("read enable outside select");
  chk_select_drop: assert property ($rose(pins_o.output_enable_n) |-> ##[1:2]
    pins_o.flag_space_select_n)
    else $error("select kept between reads");
  chk_addr_steady: assert property (!pins_o.flag_space_select_n && !$past(pins_o.flag_space_select_n)
    |-> $stable(pins_o.addr))
    else $error("address moved under select");
  chk_release_time: assert property (acc && cmd_i.op == OP_RELEASE |-> ##[6:8] done_o)
    else $error("release not done in time");
  chk_claim_order: assert property (acc && cmd_i.op == OP_CLAIM |-> ##[1:5]
    !pins_o.write_not_read ##[10:16] done_o)
    else $error("claim not write then read");
  chk_init_time: assert property (acc && cmd_i.op == OP_INIT |-> ##[46:52] done_o)
    else $error("init not done in time");
endmodule
bind sem_host_ctrl sem_host_ctrl_assertions #(.DATA_W(DATA_W)) i_sem_host_ctrl_assertions (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .cmd_valid_i(cmd_valid_i),
  .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .done_o(done_o), .pins_o(pins_o), .data_o(data_o),
  .data_oe_o(data_oe_o)
);

// File: sem_host_pkg.sv
// shared constants and types for the semaphore flag host controller
package sem_host_pkg;

  // ****************************************
  // clock and pin timing
  // ****************************************
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int T_SETUP_NS     = 5;
  localparam int T_WRITE_NS     = 10;
  localparam int T_READ_NS      = 15;
  localparam int T_GAP_NS       = 10;
  localparam int SYNC_STAGES    = 2;
  localparam int CNT_W          = 4;

  // least times round up, never below one cycle
  localparam int SETUP_CYC_I = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WRITE_CYC_I = (T_WRITE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int READ_CYC_I  = (T_READ_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + SYNC_STAGES;
  localparam int GAP_CYC_I   = (T_GAP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((SETUP_CYC_I < 1) ? 1 : SETUP_CYC_I);
  localparam logic [CNT_W-1:0] WRITE_CYC = CNT_W'((WRITE_CYC_I < 1) ? 1 : WRITE_CYC_I);
  localparam logic [CNT_W-1:0] READ_CYC  = CNT_W'(READ_CYC_I);
  localparam logic [CNT_W-1:0] GAP_CYC   = CNT_W'((GAP_CYC_I < 1) ? 1 : GAP_CYC_I);
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO  = CNT_W'(0);

  // ****************************************
  // flag space
  // ****************************************
  localparam int FLAG_COUNT = 8;
  localparam int FLAG_IDX_W = 3;
  localparam logic [FLAG_IDX_W-1:0] FLAG_FIRST = 3'h0;
  localparam logic [FLAG_IDX_W-1:0] FLAG_LAST  = 3'h7;
  localparam logic FLAG_CLAIM_VAL   = 1'b0;
  localparam logic FLAG_RELEASE_VAL = 1'b1;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    OP_TEST,
    OP_CLAIM,
    OP_RELEASE,
    OP_INIT
  } sem_op_type;

  typedef struct packed {
    sem_op_type              op;
    logic [FLAG_IDX_W-1:0]   flag;
  } sem_cmd_type;

  typedef struct packed {
    logic                    flag_space_select_n;
    logic                    chip_enable_n;
    logic                    write_not_read;
    logic                    byte_lane0_enable_n;
    logic                    output_enable_n;
    logic [FLAG_IDX_W-1:0]   addr;
  } sem_pins_type;

  localparam sem_pins_type PINS_IDLE = '{
    flag_space_select_n: 1'b1,
    chip_enable_n:       1'b1,
    write_not_read:      1'b1,
    byte_lane0_enable_n: 1'b1,
    output_enable_n:     1'b1,
    addr:                FLAG_FIRST
  };

endpackage

// File: sem_pin_sync.sv
// two-stage synchroniser for data pins coming back from the dual-port ram
`timescale 1ns/1ps
module sem_pin_sync #(
  parameter int WIDTH = 36
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta   <= '0;
      sync_o <= '0;
    end
    else if (clk_en_i)
    begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule
